// >>> common/mar_pkg.sv
/*
 * constants and types of the multichannel audio receiver
 * assumes: included by every design file through mar_pkg::*
 */
package mar_pkg;
   // ==========================================
   // register offsets (byte addresses)
   localparam logic [7:0] MAR_CTRL_OFS = 8'h04;
   localparam logic [7:0] MAR_TRANSFER_ENABLE_OFS = 8'h20;
   localparam logic [7:0] MAR_STAT_OFS = 8'h24;
   // ==========================================
   // audio_receive_control fields
   localparam int MAR_ROUTE0_LSB = 17;
   localparam int MAR_CHCNT_LSB = 15;
   localparam int MAR_PACK_BIT = 14;
   localparam int MAR_JUST_BIT = 12;
   localparam int MAR_ORDER_BIT = 11;
   localparam int MAR_SUBF_LSB = 9;
   localparam int MAR_PDLY_LSB = 7;
   localparam int MAR_FMT_LSB = 5;
   localparam int MAR_WIDTH_LSB = 0;
   localparam logic [31:0] MAR_CTRL_RST = 32'h01C8000F;
   localparam logic [31:0] MAR_FREE_MASK = 32'h01FF8000;
   localparam logic [31:0] MAR_LOCK_MASK = 32'h00005FFF;
   localparam int MAR_TRANSFER_ENABLE_RX_BIT = 1;
   localparam int MAR_STAT_LVL_LSB = 8;
   localparam int MAR_STAT_FSM_LSB = 16;
   localparam logic [4:0] MAR_WIDTH16 = 5'h0F;
   localparam logic [4:0] MAR_WIDTH32 = 5'h1F;
   localparam int MAR_PATHS = 4;
   localparam int MAR_WORD_W = 32;
   localparam int MAR_FIFO_DEPTH = 16;
   // ==========================================
   // encodings
   typedef enum logic [1:0] {
      MAR_FMT_I2S = 2'h0,
      MAR_FMT_PCM = 2'h1,
      MAR_FMT_TDM_PCM = 2'h2,
      MAR_FMT_TDM_I2S = 2'h3
   } mar_fmt_type;
   typedef enum logic [1:0] {
      MAR_SUB_STD = 2'h0,
      MAR_SUB_LJ = 2'h1,
      MAR_SUB_RJ = 2'h2,
      MAR_SUB_RSV = 2'h3
   } mar_sub_type;
   typedef enum logic [2:0] {
      MAR_ST_IDLE = 3'h1,
      MAR_ST_SKIP = 3'h2,
      MAR_ST_DATA = 3'h4
   } mar_fsm_type;
endpackage : mar_pkg

// >>> logic/mar_mem.sv
/*
 * word memory of the receive FIFO, registered read data
 * assumes: one write and one read port, caller keeps addresses in range
 */
`timescale 1ns/1ps
module mar_mem
   import mar_pkg::*;
#(
   parameter int W = MAR_WORD_W,
   parameter int DEPTH = MAR_FIFO_DEPTH,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem_ff [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
      if (rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem_ff[rd_addr];
      end
   end
endmodule : mar_mem

// >>> logic/mar_fifo.sv
/*
 * receive FIFO: memory plus one registered output stage
 * assumes: one clock, synchronous reset; out_data stays while out_valid
 */
`timescale 1ns/1ps
module mar_fifo
   import mar_pkg::*;
#(
   parameter int W = MAR_WORD_W,
   parameter int DEPTH = MAR_FIFO_DEPTH,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   output logic [AW:0] level
);
   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] cnt;
      logic ovalid;
      logic rdpend;
   } mar_fifo_state_type;

   mar_fifo_state_type state_ff;
   mar_fifo_state_type nxt_state;
   logic wr;
   logic rd;
   logic pop;

   assign in_ready = state_ff.cnt != (AW+1)'(DEPTH);
   assign wr = in_valid && in_ready;
   assign pop = state_ff.ovalid && out_ready;
   // one read in flight: trades half throughput for a simple output stage
   assign rd = (!state_ff.ovalid || pop) && !state_ff.rdpend && state_ff.cnt != '0;
   assign out_valid = state_ff.ovalid;
   assign level = state_ff.cnt;

   always_comb begin
      nxt_state = state_ff;
      if (wr) begin
         nxt_state.wptr = state_ff.wptr + 1'b1;
      end
      if (rd) begin
         nxt_state.rptr = state_ff.rptr + 1'b1;
      end
      nxt_state.cnt = state_ff.cnt + (AW+1)'(wr) - (AW+1)'(rd);
      if (pop) begin
         nxt_state.ovalid = 1'b0;
      end
      if (state_ff.rdpend) begin
         nxt_state.ovalid = 1'b1;
      end
      nxt_state.rdpend = rd;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   mar_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk(clk),
      .rst(rst),
      .wr_en(wr),
      .wr_addr(state_ff.wptr),
      .wr_data(in_data),
      .rd_en(rd),
      .rd_addr(state_ff.rptr),
      .rd_data(out_data)
   );
endmodule : mar_fifo

// >>> logic/mar_rx.sv
/*
 * receive side of an eight-channel serial audio port: routing, framing,
 * sample assembly, packing, justification and the receive FIFO
 * assumes: bit clock and frame clock come from the far side, far slower
 * than SYS_CLK; data sampled on the rising bit clock edge
 */
// Operation
// - each path takes the serial input picked by its own 2-bit route, reset path n to input n.
// - in TDM only path zero receives and the upper routes are ignored.
// - halfword packing only matters when the sample width is 16 bits.
// - unpacked 16-bit samples pair as left in bits 15:0 and right in bits 31:16.
// - packed 16-bit samples give one sample per word in the low 16 bits.
// - narrower samples are right-justified when justification is 0, left when 1.
// - for 16-bit samples justification has no effect, packed or unpacked.
// - the I2S sub-format picks standard, left- or right-justified framing.
// - the PCM delay field picks a 0 to 3 bit delay, only in PCM format.
// - the frame format picks I2S, PCM, TDM-PCM or TDM-I2S, reset I2S.
// - sample width is code plus one bits for codes 15 to 31, reset 16 bits.
// - format fields take writes only while receive transfer is disabled.
`timescale 1ns/1ps
module mar_rx
   import mar_pkg::*;
#(
   parameter int FIFO_DEPTH = MAR_FIFO_DEPTH
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   input wire logic BIT_CLK,
   input wire logic FRAME_CLK,
   input wire logic [3:0] SERIAL_INPUT,
   output logic [31:0] RX_DATA,
   output logic RX_VALID,
   input wire logic RX_READY
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic bclk_d;
      logic fclk_prev;
      mar_fsm_type fsm;
      logic [1:0] skip;
      logic [4:0] col;
      logic [3:0] slot;
      logic [3:0][31:0] sh;
      logic [3:0][15:0] half;
      logic [3:0][31:0] hold;
      logic [3:0] pend;
      logic [31:0] ctrl;
      logic [1:0] transfer_enable;
      logic ovf;
      logic [31:0] rdata;
   } mar_rx_state_type;

   mar_rx_state_type state_ff;
   mar_rx_state_type nxt_state;

   // ==========================================
   // control field views
   mar_fmt_type fmt;
   mar_sub_type subf;
   logic [1:0] pdly;
   logic [1:0] chcnt;
   logic [4:0] wcode;
   logic [4:0] sh_amt;
   logic pack;
   logic just;
   logic lsb_first;
   logic rx_on;
   logic tdm;
   logic w16;
   logic rj;
   logic [1:0] dly;
   logic [3:0] nslot;
   logic [3:0] act_mask;
   logic [31:0] wmask;

   assign fmt = mar_fmt_type'(state_ff.ctrl[MAR_FMT_LSB +: 2]);
   assign subf = mar_sub_type'(state_ff.ctrl[MAR_SUBF_LSB +: 2]);
   assign pdly = state_ff.ctrl[MAR_PDLY_LSB +: 2];
   assign chcnt = state_ff.ctrl[MAR_CHCNT_LSB +: 2];
   assign wcode = state_ff.ctrl[MAR_WIDTH_LSB +: 5];
   assign sh_amt = MAR_WIDTH32 - wcode;
   assign pack = state_ff.ctrl[MAR_PACK_BIT];
   assign just = state_ff.ctrl[MAR_JUST_BIT];
   assign lsb_first = state_ff.ctrl[MAR_ORDER_BIT];
   assign rx_on = state_ff.transfer_enable[MAR_TRANSFER_ENABLE_RX_BIT];
   assign tdm = fmt[1];
   assign w16 = wcode == MAR_WIDTH16;
   assign rj = fmt == MAR_FMT_I2S && subf == MAR_SUB_RJ;

   // sub-format and pcm delay pick the skip count
   always_comb begin
      case (fmt)
         MAR_FMT_I2S: dly = (subf == MAR_SUB_LJ) ? 2'h0 : 2'h1;
         MAR_FMT_PCM: dly = pdly;
         MAR_FMT_TDM_PCM: dly = 2'h0;
         MAR_FMT_TDM_I2S: dly = 2'h1;
         default: dly = 2'h1;
      endcase
   end

   assign nslot = (fmt == MAR_FMT_I2S) ? 4'h1 :
                  (fmt == MAR_FMT_PCM) ? 4'h2 : 4'({chcnt, 1'b0}) + 4'h2;
   assign act_mask = tdm ? 4'h1 : {chcnt == 2'h3, chcnt[1], chcnt != 2'h0, 1'b1};
   assign wmask = rx_on ? MAR_FREE_MASK : (MAR_FREE_MASK | MAR_LOCK_MASK);

   // ==========================================
   // link sampling
   logic bit_edge;
   logic fclk;
   logic [3:0] sd;
   logic frame_ev;

   assign bit_edge = state_ff.sync2[0] && !state_ff.bclk_d;
   assign fclk = state_ff.sync2[1];
   assign sd = state_ff.sync2[5:2];
   assign frame_ev = (fmt == MAR_FMT_I2S) ? (fclk != state_ff.fclk_prev) :
                     (fclk && !state_ff.fclk_prev);

   // ==========================================
   // per path assembly
   logic [3:0] pbit;
   logic [3:0][31:0] shin;
   logic [3:0][31:0] raw;
   logic [3:0][31:0] pword;
   logic [3:0][15:0] phalf;
   logic [1:0] route1;

   assign route1 = state_ff.ctrl[MAR_ROUTE0_LSB + 2 +: 2];

   genvar gi;
   for (gi = 0; gi < MAR_PATHS; gi++) begin : g_path
      logic [1:0] route;
      logic [31:0] src;
      assign route = state_ff.ctrl[MAR_ROUTE0_LSB + 2*gi +: 2];
      assign pbit[gi] = sd[route];
      assign shin[gi] = lsb_first ? {pbit[gi], state_ff.sh[gi][31:1]} :
                                    {state_ff.sh[gi][30:0], pbit[gi]};
      assign src = rj ? state_ff.sh[gi] : shin[gi];
      assign raw[gi] = lsb_first ? (src >> sh_amt) : (src & (32'hFFFFFFFF >> sh_amt));
      assign phalf[gi] = raw[gi][15:0];
      // pair, packed low half, justify other widths
      assign pword[gi] = (w16 && !pack) ? {raw[gi][15:0], state_ff.half[gi]} :
                         (w16 || !just) ? raw[gi] : (raw[gi] << sh_amt);
   end

   // ==========================================
   // receive sequencing and FIFO feed
   mar_fsm_type st_now;
   logic [1:0] skip_now;
   logic [4:0] col_now;
   logic [3:0] slot_now;
   logic cap;
   logic cap_left;
   logic [1:0] idx;
   logic push_valid;
   logic [31:0] push_data;
   logic fifo_ready;
   logic [LW-1:0] fifo_level;

   assign idx = state_ff.pend[0] ? 2'h0 : state_ff.pend[1] ? 2'h1 :
                state_ff.pend[2] ? 2'h2 : 2'h3;
   assign push_valid = |state_ff.pend;
   assign push_data = state_ff.hold[idx];

   always_comb begin
      nxt_state = state_ff;
      cap = 1'b0;
      cap_left = 1'b0;
      st_now = state_ff.fsm;
      skip_now = state_ff.skip;
      col_now = state_ff.col;
      slot_now = state_ff.slot;
      nxt_state.sync1 = {SERIAL_INPUT, FRAME_CLK, BIT_CLK};
      nxt_state.sync2 = state_ff.sync1;
      nxt_state.bclk_d = state_ff.sync2[0];
      if (frame_ev) begin
         st_now = (dly == 2'h0) ? MAR_ST_DATA : MAR_ST_SKIP;
         skip_now = dly;
         col_now = 5'h00;
         slot_now = (fmt == MAR_FMT_I2S) ? {3'h0, fclk} : 4'h0;
      end
      if (!rx_on) begin
         nxt_state.fsm = MAR_ST_IDLE;
         nxt_state.fclk_prev = fclk;
      end else if (bit_edge) begin
         nxt_state.fclk_prev = fclk;
         nxt_state.slot = slot_now;
         nxt_state.col = col_now;
         nxt_state.skip = skip_now;
         if (rj) begin
            // right-justified: the word ends at the frame edge
            nxt_state.sh = shin;
            cap = frame_ev;
            cap_left = !state_ff.fclk_prev;
         end else begin
            case (st_now)
               MAR_ST_SKIP: begin
                  nxt_state.skip = skip_now - 2'h1;
                  nxt_state.fsm = (skip_now == 2'h1) ? MAR_ST_DATA : MAR_ST_SKIP;
               end
               MAR_ST_DATA: begin
                  nxt_state.sh = shin;
                  nxt_state.col = col_now + 5'h01;
                  nxt_state.fsm = MAR_ST_DATA;
                  // sample ends after code plus one bits
                  if (col_now == wcode) begin
                     cap = 1'b1;
                     cap_left = !slot_now[0];
                     nxt_state.col = 5'h00;
                     nxt_state.slot = slot_now + 4'h1;
                     if (slot_now + 4'h1 >= nslot) begin
                        nxt_state.fsm = MAR_ST_IDLE;
                     end
                  end
               end
               default: nxt_state.fsm = MAR_ST_IDLE;
            endcase
         end
      end
      if (push_valid && fifo_ready) begin
         nxt_state.pend[idx] = 1'b0;
      end
      // register writes honour the lock mask
      if (REG_WR) begin
         case (REG_ADDR)
            MAR_CTRL_OFS: nxt_state.ctrl = (state_ff.ctrl & ~wmask) | (REG_WDATA & wmask);
            MAR_TRANSFER_ENABLE_OFS: nxt_state.transfer_enable = REG_WDATA[1:0];
            MAR_STAT_OFS: nxt_state.ovf = state_ff.ovf && !REG_WDATA[0];
            default: ;
         endcase
      end
      if (cap) begin
         // left half waits for its right partner
         if (w16 && !pack && cap_left) begin
            nxt_state.half = phalf;
         end else begin
            // overrun: the far side cannot be stalled, so the old words are lost
            if (|nxt_state.pend) begin
               nxt_state.ovf = 1'b1;
            end
            nxt_state.hold = pword;
            nxt_state.pend = act_mask;
         end
      end
      nxt_state.rdata = 32'h00000000;
      if (REG_RD) begin
         case (REG_ADDR)
            MAR_CTRL_OFS: nxt_state.rdata = state_ff.ctrl;
            MAR_TRANSFER_ENABLE_OFS: nxt_state.rdata = {30'h0, state_ff.transfer_enable};
            MAR_STAT_OFS: begin
               nxt_state.rdata[0] = state_ff.ovf;
               nxt_state.rdata[MAR_STAT_LVL_LSB +: LW] = fifo_level;
               nxt_state.rdata[MAR_STAT_FSM_LSB +: 3] = state_ff.fsm;
            end
            default: nxt_state.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_ff <= '0;
         state_ff.ctrl <= MAR_CTRL_RST;
         state_ff.fsm <= MAR_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign REG_RDATA = state_ff.rdata;

   mar_fifo #(.W(MAR_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(SYS_CLK),
      .rst(RST),
      .in_valid(push_valid),
      .in_data(push_data),
      .in_ready(fifo_ready),
      .out_valid(RX_VALID),
      .out_data(RX_DATA),
      .out_ready(RX_READY),
      .level(fifo_level)
   );

   // ==========================================
   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   reset_values_a: assert property ($past(RST) |-> state_ff.ctrl == MAR_CTRL_RST)
      else $error("control register reset value wrong");
   route_path_a: assert property (rx_on && bit_edge && !rj && st_now == MAR_ST_DATA
      && !lsb_first |=> state_ff.sh[1][0] == $past(sd[route1]))
      else $error("path one took the wrong input");
   tdm_single_a: assert property (cap && tdm |=> state_ff.pend[3:1] == 3'h0)
      else $error("upper path pushed in TDM");
   pack_width_a: assert property (cap && !w16 |=> state_ff.pend[0])
      else $error("packing affected non 16-bit width");
   pair_half_a: assert property (cap && w16 && !pack && cap_left
      |=> state_ff.half[0] == $past(raw[0][15:0]))
      else $error("left half not kept");
   packed_low_a: assert property (push_valid && rx_on && w16 && pack
      |-> push_data[31:16] == 16'h0000)
      else $error("packed word upper half not empty");
   right_just_a: assert property (cap && !w16 && !just && wcode != MAR_WIDTH32
      |=> (state_ff.hold[0] >> (6'($past(wcode)) + 6'h01)) == 32'h0)
      else $error("right justified word has high bits");
   just_ignored_a: assert property (cap && w16 && pack && just
      |=> state_ff.hold[0][31:16] == 16'h0000)
      else $error("justification applied to packed 16-bit");
   lj_delay_a: assert property (fmt == MAR_FMT_I2S && subf == MAR_SUB_LJ |-> dly == 2'h0)
      else $error("left justified framing has a delay");
   pcm_delay_a: assert property (fmt == MAR_FMT_PCM |-> dly == pdly)
      else $error("pcm delay not applied");
   lock_fields_a: assert property (REG_WR && REG_ADDR == MAR_CTRL_OFS && rx_on
      |=> (state_ff.ctrl & MAR_LOCK_MASK) == $past(state_ff.ctrl & MAR_LOCK_MASK))
      else $error("locked field changed while enabled");
   chan_mask_a: assert property (cap && !tdm
      |=> (state_ff.pend & ~$past(act_mask)) == 4'h0)
      else $error("inactive path pushed");
endmodule : mar_rx

// >>> test/mar_codec.sv
/*
 * serial audio source standing at the far side of the receiver
 * assumes: the bench calls send_frame; bit clock period 800 ns, idle between frames
 */
`timescale 1ns/1ps
module mar_codec (
   output logic BIT_CLK,
   output logic FRAME_CLK,
   output logic [3:0] SERIAL_INPUT
);
   logic bit_line = 1'b0;
   logic [1:0] pin_sel = 2'h0;
   initial begin
      BIT_CLK = 1'b0;
      FRAME_CLK = 1'b1;
   end
   // unselected pins carry the inverse, so a wrong route gives wrong data
   assign SERIAL_INPUT = (4'h1 << pin_sel) ^ {4{~bit_line}};
   // ==========================================
   // one frame: pcm 0 holds one frame level per channel, pcm 1 gives a start pulse
   task automatic send_frame(input bit pcm, input int dly, input int w, input int chlen,
         input int nslots, input logic [1:0] pin, input logic [31:0] s [8]);
      int k;
      int p;
      pin_sel = pin;
      // odd offset keeps bit edges clear of the system clock edges
      #37;
      for (int g = pcm ? -1 : 0; g < (pcm ? dly + nslots * w + 2 : 2 * chlen); g++) begin
         k = pcm ? (g - dly) / w : g / chlen;
         p = pcm ? (g - dly) % w : g % chlen - dly;
         FRAME_CLK = pcm ? (g == 0) : (k == 1);
         // idle positions toggle rather than hold the last bit
         if (p >= 0 && p < w && g >= dly && k < nslots)
            bit_line = s[k][w - 1 - p];
         else
            bit_line = ~bit_line;
         #400 BIT_CLK = 1'b1;
         #400 BIT_CLK = 1'b0;
      end
      bit_line = ~bit_line;
   endtask : send_frame
endmodule : mar_codec

// >>> test/multichannel_audio_rx_config_test.sv
/*
 * self-checking bench of the audio receiver: registers, framing, packing, FIFO
 * assumes: mar_codec drives the serial side; 10 MHz system clock
 */
`timescale 1ns/1ps
module multichannel_audio_rx_config_test;
   import mar_pkg::*;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h0;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [31:0] REG_RDATA;
   logic BIT_CLK;
   logic FRAME_CLK;
   logic [3:0] SERIAL_INPUT;
   logic [31:0] RX_DATA;
   logic RX_VALID;
   logic RX_READY = 1'b0;
   logic rdy_en = 1'b1;
   int fails = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'hD0D3;
   logic [31:0] got [$];
   logic [31:0] slots [8];
   mar_rx dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BIT_CLK(BIT_CLK),
      .FRAME_CLK(FRAME_CLK), .SERIAL_INPUT(SERIAL_INPUT), .RX_DATA(RX_DATA),
      .RX_VALID(RX_VALID), .RX_READY(RX_READY));
   mar_codec codec_u (.BIT_CLK(BIT_CLK), .FRAME_CLK(FRAME_CLK), .SERIAL_INPUT(SERIAL_INPUT));
   always #50 SYS_CLK = ~SYS_CLK;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] rev(input logic [31:0] v, input int w);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < w; i++) r[i] = v[w - 1 - i];
      return r;
   endfunction : rev
   function automatic logic [31:0] mk(input logic [1:0] r0, input logic [1:0] cc,
         input logic pk, input logic js, input logic od, input logic [1:0] sb,
         input logic [1:0] pd, input logic [1:0] fm, input logic [4:0] wc);
      return {7'h00, 6'h39, r0, cc, pk, 1'b0, js, od, sb, pd, fm, wc};
   endfunction : mk
   // ==========================================
   // consumer: random stalls while words are collected
   always @(posedge SYS_CLK) begin
      if (RX_VALID === 1'b1 && RX_READY) got.push_back(RX_DATA);
      RX_READY <= rdy_en && (rnd() > 32'h7FFFFFFF);
   end
   task automatic chk(input logic [31:0] a, input logic [31:0] e, input string what);
      n_compared++;
      if (a !== e) begin
         fails++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, a, e);
      end
   endtask : chk
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      @(negedge SYS_CLK);
      d = REG_RDATA;
   endtask : reg_rd
   // ==========================================
   // one configured frame, expected words worked out from the control fields
   task automatic run(input logic [31:0] c, input bit pcm, input int dly, input int ns);
      int w;
      int n;
      int np;
      logic [31:0] s;
      logic [15:0] lft [4];
      logic [31:0] ex [$];
      w = c[4:0] + 1;
      // in TDM only path zero delivers
      np = c[6] ? 1 : c[16:15] + 1;
      reg_wr(MAR_TRANSFER_ENABLE_OFS, 32'h0);
      reg_wr(MAR_CTRL_OFS, c);
      reg_wr(MAR_TRANSFER_ENABLE_OFS, 32'h2);
      for (int k = 0; k < 8; k++) slots[k] = rnd();
      codec_u.send_frame(pcm, dly, w, w + 2, ns, c[18:17], slots);
      // a right-justified word closes at a level change: a second frame ends the right one
      if (c[6:5] == 2'h0 && c[10:9] == 2'h2)
         codec_u.send_frame(pcm, dly, w, w + 2, ns, c[18:17], slots);
      for (int k = 0; k < ns; k++) begin
         for (int q = 0; q < np; q++) begin
            s = slots[k] & (32'hFFFFFFFF >> (32 - w));
            // a path routed to another input sees the inverse of the sent bits
            if (c[17 + 2 * q +: 2] != c[18:17]) s = ~s & (32'hFFFFFFFF >> (32 - w));
            if (c[11]) s = rev(s, w);
            if (w == 16 && !c[14]) begin
               if (k % 2 == 0) lft[q] = s[15:0];
               else ex.push_back({s[15:0], lft[q]});
            end else if (w == 16) ex.push_back({16'h0, s[15:0]});
            else ex.push_back(c[12] ? s << (32 - w) : s);
         end
      end
      if (c[6:5] == 2'h0 && c[10:9] == 2'h2) begin
         for (int q = 0; q < np; q++) ex.push_back(ex[q]);
      end
      n = 0;
      while (got.size() < ex.size() && n < 400) begin
         @(posedge SYS_CLK);
         n++;
      end
      // a short quiet spell shows that no extra words follow
      repeat (30) @(posedge SYS_CLK);
      chk(got.size(), ex.size(), "word count");
      for (int k = 0; k < ex.size() && k < got.size(); k++) chk(got[k], ex[k], "word");
      got.delete();
   endtask : run
   initial begin
      #5000000;
      fails++;
      stop_test();
   end
   initial begin
      logic [31:0] r;
      logic [31:0] rd;
      logic [31:0] sh;
      repeat (16) @(posedge SYS_CLK);
      RST <= 1'b0;
      reg_rd(MAR_CTRL_OFS, rd);
      chk(rd, MAR_CTRL_RST, "control reset");
      reg_rd(MAR_TRANSFER_ENABLE_OFS, rd);
      chk(rd, 32'h0, "transfer reset");
      reg_rd(8'h10, rd);
      chk(rd, 32'h0, "unmapped read");
      sh = rnd();
      reg_wr(MAR_CTRL_OFS, sh);
      reg_rd(MAR_CTRL_OFS, rd);
      chk(rd, sh & (MAR_FREE_MASK | MAR_LOCK_MASK), "idle write");
      reg_wr(MAR_TRANSFER_ENABLE_OFS, 32'h2);
      r = rnd();
      reg_wr(MAR_CTRL_OFS, r);
      reg_wr(8'h10, 32'hFFFFFFFF);
      reg_rd(MAR_CTRL_OFS, rd);
      chk(rd, (r & MAR_FREE_MASK) | (sh & MAR_LOCK_MASK), "locked write");
      r = rnd();
      run(mk(r[1:0], 2'h1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0, 5'h0F), 0, 1, 2);
      run(mk(r[3:2], 2'h0, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0, 5'h0F), 0, 1, 2);
      // packing ignored at 24 bits, left-justified framing
      run(mk(r[5:4], 2'h0, 1'b1, 1'b0, 1'b0, 2'h1, 2'h0, 2'h0, 5'h17), 0, 0, 2);
      run(mk(r[7:6], 2'h3, 1'b0, 1'b1, 1'b1, 2'h0, 2'h0, 2'h0, 5'h17), 0, 1, 2);
      // reserved sub-format acts as standard, full width
      run(mk(r[9:8], 2'h0, 1'b0, 1'b0, 1'b0, 2'h3, 2'h0, 2'h0, 5'h1F), 0, 1, 2);
      for (int d = 0; d < 4; d++) begin
         r = rnd();
         run(mk(r[1:0], r[7:6], 1'b0, r[2], 1'b0, 2'h2, d[1:0], 2'h1, 5'h10 + r[5:3]),
            1, d, 2);
      end
      // right-justified framing, sample closed by the level change
      run(mk(r[1:0], 2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 2'h0, 2'h0, 5'h13), 0, 2, 2);
      r = rnd();
      // TDM on path zero only, delay field ignored
      run(mk(r[1:0], 2'h1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h3, 2'h2, 5'h1F), 1, 0, 4);
      run(mk(r[3:2], 2'h3, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 2'h3, 5'h1B), 1, 1, 8);
      // ==========================================
      // overrun: consumer stalls through three full TDM frames
      rdy_en <= 1'b0;
      reg_wr(MAR_TRANSFER_ENABLE_OFS, 32'h0);
      reg_wr(MAR_CTRL_OFS, mk(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h2, 5'h1F));
      reg_wr(MAR_TRANSFER_ENABLE_OFS, 32'h2);
      repeat (3) codec_u.send_frame(1'b1, 0, 32, 34, 8, 2'h0, slots);
      repeat (30) @(posedge SYS_CLK);
      reg_rd(MAR_STAT_OFS, rd);
      chk({31'h0, rd[0]}, 32'h1, "overrun set");
      reg_wr(MAR_STAT_OFS, 32'h1);
      reg_rd(MAR_STAT_OFS, rd);
      chk({31'h0, rd[0]}, 32'h0, "overrun clear");
      rdy_en <= 1'b1;
      repeat (300) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk({31'h0, RX_VALID}, 32'h0, "drained");
      reg_rd(MAR_STAT_OFS, rd);
      chk({27'h0, rd[12:8]}, 32'h0, "level empty");
      stop_test();
   end
endmodule : multichannel_audio_rx_config_test
